//--- ctk_pkg.sv
// constants shared by the calendar timekeeper files
package ctk_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;

  // register offsets on the i/o bus
  localparam logic [15:0] OFF_SEC     = 16'h00e0;
  localparam logic [15:0] OFF_MIN     = 16'h00e1;
  localparam logic [15:0] OFF_HRS     = 16'h00e2;
  localparam logic [15:0] OFF_DOW     = 16'h00e3;
  localparam logic [15:0] OFF_DOM     = 16'h00e4;
  localparam logic [15:0] OFF_MON     = 16'h00e5;
  localparam logic [15:0] OFF_YR      = 16'h00e6;
  localparam logic [15:0] OFF_CEN     = 16'h00e7;
  localparam logic [15:0] OFF_AL_SEC  = 16'h00e8;
  localparam logic [15:0] OFF_AL_MIN  = 16'h00e9;
  localparam logic [15:0] OFF_AL_HRS  = 16'h00ea;
  localparam logic [15:0] OFF_AL_DOW  = 16'h00eb;
  localparam logic [15:0] OFF_AL_EN   = 16'h00ec;
  localparam logic [15:0] OFF_CTRL    = 16'h00ed;

  // timekeeper_control bit positions
  localparam int unsigned CTRL_FLAG   = 7;
  localparam int unsigned CTRL_IRQEN  = 6;
  localparam int unsigned CTRL_BCD    = 5;
  localparam int unsigned CTRL_SRC    = 4;
  localparam int unsigned CTRL_LINE50 = 3;
  localparam int unsigned CTRL_UNLOCK = 0;

  // alarm enable bit positions
  localparam int unsigned EN_SEC = 0;
  localparam int unsigned EN_MIN = 1;
  localparam int unsigned EN_HRS = 2;
  localparam int unsigned EN_DOW = 3;

  // values after reset
  localparam logic       RST_UNLOCK = 1'b0;
  localparam logic       RST_IRQEN  = 1'b0;
  localparam logic       RST_BCD    = 1'b0;
  localparam logic       RST_SRC    = 1'b0;
  localparam logic       RST_LINE50 = 1'b0;
  localparam logic [3:0] RST_AL_EN  = 4'h0;

  // count ranges, binary
  localparam logic [7:0] SEC_MAX = 8'h3b;
  localparam logic [7:0] MIN_MAX = 8'h3b;
  localparam logic [7:0] HRS_MAX = 8'h17;
  localparam logic [7:0] DOW_MIN = 8'h01;
  localparam logic [7:0] DOW_MAX = 8'h07;
  localparam logic [7:0] DOM_MIN = 8'h01;
  localparam logic [7:0] MON_MIN = 8'h01;
  localparam logic [7:0] MON_MAX = 8'h0c;
  localparam logic [7:0] YR_MAX  = 8'h63;
  localparam logic [7:0] CEN_MAX = 8'h63;

  // source edges per second
  localparam int unsigned DIV_W      = 16;
  localparam logic [15:0] XTAL_EDGES = 16'h8000;
  localparam logic [15:0] LINE50_EDGES = 16'h0032;
  localparam logic [15:0] LINE60_EDGES = 16'h003c;

endpackage

//--- ctk_div_if.sv
// carrier between the timekeeper core and its divider
`timescale 1ns/100ps
interface ctk_div_if;
  logic        src_edge;
  logic        clr;
  logic        run;
  logic [15:0] limit;
  logic        tick;

  modport ctl
  (
    output src_edge,
    output clr,
    output run,
    output limit,
    input  tick
  );

  modport div
  (
    input  src_edge,
    input  clr,
    input  run,
    input  limit,
    output tick
  );
endinterface

//--- ctk_divider.sv
// prescaling divider giving one tick per second
`timescale 1ns/100ps
module ctk_divider
(
  input wire logic mclk,
  input wire logic reset,
  ctk_div_if.div   dv
);

  typedef struct packed
  {
    logic [15:0] cnt;
    logic        tick;
  } ctk_div_s;

  ctk_div_s r;
  ctk_div_s next_r;

  assign dv.tick = r.tick;

  always_comb
  begin
    next_r      = r;
    next_r.tick = 1'b0;
    // (R11) restart on clear
    if (dv.clr)
    begin
      next_r.cnt = 16'h0000;
    end
    // (R19) one tick per second
    else if (dv.run && dv.src_edge)
    begin
      if (r.cnt >= dv.limit - 16'h0001)
      begin
        next_r.cnt  = 16'h0000;
        next_r.tick = 1'b1;
      end
      else
      begin
        next_r.cnt = r.cnt + 16'h0001;
      end
    end
    if (reset)
    begin
      next_r = '0;
    end
  end

  always_ff @(posedge mclk)
  begin
    r <= next_r;
  end

endmodule

//--- ctk_calendar_timekeeper.sv
// calendar timekeeper core with alarm and i/o register access
`timescale 1ns/100ps

// Overview of operation
// (R1) counts seconds to century; hours run 0 to 23
// (R2) count and alarm registers in binary or packed bcd per format bit
// (R3) day of month rolls per month length, leap years handled
// (R4) alarm fires when every enabled set-point equals the count
// (R5) alarm with interrupt enable set raises the interrupt line
// (R6) reading control clears the alarm flag and interrupt
// (R7) alarm set-points and enables writable whatever the lock
// (R8) alarm compared each time the count advances once a second
// (R9) writing unlock as 0 forces a comparison, even if already 0
// (R10) tick from crystal or 50/60 hz line, chosen in control
// (R11) any control write restarts the divider
// (R12) alarm enables cleared at power-up; counts undefined
// (R13) software: unlock, set counts, set alarms, then lock
// (R14) clearing unlock restarts the divider then lets it run
// (R15) unlocked stops count and allows count writes; locked ignores them
// (R16) reset leaves the block locked and counting
// (R17) count registers keep their value through reset
// (R18) seconds bcd tens in [7:4], units in [3:0]; binary 00h-3bh
// (R19) divider gives one tick per 32768 crystal or 50/60 line edges
module ctk_calendar_timekeeper
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [15:0] io_addr,
  input  wire logic [7:0]  io_wdata,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic        xtal_clk,
  input  wire logic        line_clk,
  output logic      [7:0]  io_rdata,
  output logic             alarm_irq
);

  typedef struct packed
  {
    logic [7:0] time_unit_count;
    logic [7:0] minutes;
    logic [7:0] hours;
    logic [7:0] weekday;
    logic [7:0] monthday;
    logic [7:0] month;
    logic [7:0] year;
    logic [7:0] century;
    logic [7:0] al_sec;
    logic [7:0] al_min;
    logic [7:0] al_hrs;
    logic [7:0] al_dow;
    logic [3:0] al_en;
    logic       count_write_unlock;
    logic       alarm_irq_enable;
    logic       decimal_format_select;
    logic       line_source;
    logic       line_50hz;
    logic       alarm_match_flag;
    logic       irq;
    logic       cmp_pend;
    logic       xtal_q;
    logic       line_q;
    logic [7:0] rdata;
  } ctk_state_s;

  ctk_state_s r;
  ctk_state_s next_r;
  ctk_div_if  dif ();

  // wrap or advance one count field
  function automatic logic [8:0] ctk_step(input logic [7:0] v, input logic [7:0] lo,
                                          input logic [7:0] hi, input logic bcd);
    if (v >= hi)
    begin
      return {1'b1, lo};
    end
    else if (bcd && v[3:0] == 4'h9)
    begin
      return {1'b0, v[7:4] + 4'h1, 4'h0};
    end
    return {1'b0, v + 8'h01};
  endfunction

  // binary value into register format
  function automatic logic [7:0] ctk_fmt(input logic [7:0] b, input logic bcd);
    logic [7:0] tens;
    logic [7:0] ones;
    tens = b / 8'h0a;
    ones = b % 8'h0a;
    return bcd ? {tens[3:0], ones[3:0]} : b;
  endfunction

  // register format into binary value
  function automatic logic [7:0] ctk_bin(input logic [7:0] v, input logic bcd);
    return bcd ? 8'(8'(v[7:4]) * 8'h0a + 8'(v[3:0])) : v;
  endfunction

  // days in a month, binary month
  function automatic logic [7:0] ctk_days(input logic [7:0] mon, input logic leap);
    case (mon)
      8'h02:   return leap ? 8'h1d : 8'h1c;
      8'h04:   return 8'h1e;
      8'h06:   return 8'h1e;
      8'h09:   return 8'h1e;
      8'h0b:   return 8'h1e;
      default: return 8'h1f;
    endcase
  endfunction

  logic       bcd;
  logic       wr_cnt;
  logic       wr_ctrl;
  logic       leap;
  logic       any_en;
  logic       match;
  logic [7:0] yr_b;
  logic [7:0] cen_b;
  logic [8:0] st;
  logic [8:0] st_dow;

  assign bcd     = r.decimal_format_select;
  // (R15) count writes only while unlocked
  assign wr_cnt  = io_wr && r.count_write_unlock;
  assign wr_ctrl = io_wr && io_addr == ctk_pkg::OFF_CTRL;
  assign yr_b    = ctk_bin(r.year, bcd);
  assign cen_b   = ctk_bin(r.century, bcd);
  // (R3) leap year by year and century
  assign leap    = yr_b[1:0] == 2'b00 && (yr_b != 8'h00 || cen_b[1:0] == 2'b00);

  // (R10) source and line frequency select
  assign dif.src_edge = r.line_source ? (line_clk && !r.line_q) : (xtal_clk && !r.xtal_q);
  assign dif.limit    = r.line_source ? (r.line_50hz ? ctk_pkg::LINE50_EDGES : ctk_pkg::LINE60_EDGES)
                                      : ctk_pkg::XTAL_EDGES;
  // (R11) control write clears divider
  assign dif.clr      = wr_ctrl;
  // (R14) divider runs only while locked
  assign dif.run      = !r.count_write_unlock;

  ctk_divider u_div
  (
    .mclk  (mclk),
    .reset (reset),
    .dv    (dif.div)
  );

  // (R4) all enabled set-points equal
  assign any_en = |r.al_en;
  assign match  = any_en
               && (!r.al_en[ctk_pkg::EN_SEC] || r.al_sec == r.time_unit_count)
               && (!r.al_en[ctk_pkg::EN_MIN] || r.al_min == r.minutes)
               && (!r.al_en[ctk_pkg::EN_HRS] || r.al_hrs == r.hours)
               && (!r.al_en[ctk_pkg::EN_DOW] || r.al_dow == r.weekday);

  assign io_rdata  = r.rdata;
  assign alarm_irq = r.irq;

  always_comb
  begin
    next_r          = r;
    st              = 9'h000;
    st_dow          = 9'h000;
    next_r.xtal_q   = xtal_clk;
    next_r.line_q   = line_clk;
    next_r.cmp_pend = 1'b0;

    // (R1) count chain on each tick
    if (dif.tick && !r.count_write_unlock)
    begin
      // (R8) compare after the advance
      next_r.cmp_pend = 1'b1;
      // (R18) seconds wrap at 59
      st = ctk_step(r.time_unit_count, 8'h00, ctk_fmt(ctk_pkg::SEC_MAX, bcd), bcd);
      next_r.time_unit_count = st[7:0];
      if (st[8])
      begin
        st = ctk_step(r.minutes, 8'h00, ctk_fmt(ctk_pkg::MIN_MAX, bcd), bcd);
        next_r.minutes = st[7:0];
      end
      if (st[8])
      begin
        st = ctk_step(r.hours, 8'h00, ctk_fmt(ctk_pkg::HRS_MAX, bcd), bcd);
        next_r.hours = st[7:0];
      end
      if (st[8])
      begin
        st_dow         = ctk_step(r.weekday, ctk_pkg::DOW_MIN, ctk_pkg::DOW_MAX, bcd);
        next_r.weekday = st_dow[7:0];
        // (R3) month length and leap day
        st = ctk_step(r.monthday, ctk_pkg::DOM_MIN,
                      ctk_fmt(ctk_days(ctk_bin(r.month, bcd), leap), bcd), bcd);
        next_r.monthday = st[7:0];
      end
      if (st[8])
      begin
        st = ctk_step(r.month, ctk_pkg::MON_MIN, ctk_fmt(ctk_pkg::MON_MAX, bcd), bcd);
        next_r.month = st[7:0];
      end
      if (st[8])
      begin
        st = ctk_step(r.year, 8'h00, ctk_fmt(ctk_pkg::YR_MAX, bcd), bcd);
        next_r.year = st[7:0];
      end
      if (st[8])
      begin
        st             = ctk_step(r.century, 8'h00, ctk_fmt(ctk_pkg::CEN_MAX, bcd), bcd);
        next_r.century = st[7:0];
      end
    end

    // (R2) values stored as written in the chosen format
    if (wr_cnt)
    begin
      case (io_addr)
        ctk_pkg::OFF_SEC: next_r.time_unit_count = io_wdata;
        ctk_pkg::OFF_MIN: next_r.minutes         = io_wdata;
        ctk_pkg::OFF_HRS: next_r.hours           = io_wdata;
        ctk_pkg::OFF_DOW: next_r.weekday         = {4'h0, io_wdata[3:0]};
        ctk_pkg::OFF_DOM: next_r.monthday        = io_wdata;
        ctk_pkg::OFF_MON: next_r.month           = io_wdata;
        ctk_pkg::OFF_YR:  next_r.year            = io_wdata;
        ctk_pkg::OFF_CEN: next_r.century         = io_wdata;
        default:          next_r.century         = next_r.century;
      endcase
    end

    // (R7) alarm registers writable regardless of lock
    if (io_wr)
    begin
      case (io_addr)
        ctk_pkg::OFF_AL_SEC: next_r.al_sec = io_wdata;
        ctk_pkg::OFF_AL_MIN: next_r.al_min = io_wdata;
        ctk_pkg::OFF_AL_HRS: next_r.al_hrs = io_wdata;
        ctk_pkg::OFF_AL_DOW: next_r.al_dow = {4'h0, io_wdata[3:0]};
        ctk_pkg::OFF_AL_EN:  next_r.al_en  = io_wdata[3:0];
        default:             next_r.al_en  = next_r.al_en;
      endcase
    end

    if (wr_ctrl)
    begin
      next_r.count_write_unlock    = io_wdata[ctk_pkg::CTRL_UNLOCK];
      next_r.alarm_irq_enable      = io_wdata[ctk_pkg::CTRL_IRQEN];
      next_r.decimal_format_select = io_wdata[ctk_pkg::CTRL_BCD];
      next_r.line_source           = io_wdata[ctk_pkg::CTRL_SRC];
      next_r.line_50hz             = io_wdata[ctk_pkg::CTRL_LINE50];
      // (R9) forced comparison on writing lock
      if (!io_wdata[ctk_pkg::CTRL_UNLOCK])
      begin
        next_r.cmp_pend = 1'b1;
      end
    end

    // register read port
    if (io_rd)
    begin
      case (io_addr)
        ctk_pkg::OFF_SEC:    next_r.rdata = r.time_unit_count;
        ctk_pkg::OFF_MIN:    next_r.rdata = r.minutes;
        ctk_pkg::OFF_HRS:    next_r.rdata = r.hours;
        ctk_pkg::OFF_DOW:    next_r.rdata = {4'h0, r.weekday[3:0]};
        ctk_pkg::OFF_DOM:    next_r.rdata = r.monthday;
        ctk_pkg::OFF_MON:    next_r.rdata = r.month;
        ctk_pkg::OFF_YR:     next_r.rdata = r.year;
        ctk_pkg::OFF_CEN:    next_r.rdata = r.century;
        ctk_pkg::OFF_AL_SEC: next_r.rdata = r.al_sec;
        ctk_pkg::OFF_AL_MIN: next_r.rdata = r.al_min;
        ctk_pkg::OFF_AL_HRS: next_r.rdata = r.al_hrs;
        ctk_pkg::OFF_AL_DOW: next_r.rdata = {4'h0, r.al_dow[3:0]};
        ctk_pkg::OFF_AL_EN:  next_r.rdata = {4'h0, r.al_en};
        ctk_pkg::OFF_CTRL:   next_r.rdata = {r.alarm_match_flag, r.alarm_irq_enable,
                                             r.decimal_format_select, r.line_source,
                                             r.line_50hz, 2'b00, r.count_write_unlock};
        default:             next_r.rdata = 8'h00;
      endcase
      // (R6) control read clears flag
      if (io_addr == ctk_pkg::OFF_CTRL)
      begin
        next_r.alarm_match_flag = 1'b0;
      end
    end

    // (R4) set wins over the read clear
    if (r.cmp_pend && match)
    begin
      next_r.alarm_match_flag = 1'b1;
    end

    // (R5) interrupt follows flag and enable
    next_r.irq = next_r.alarm_match_flag && next_r.alarm_irq_enable;

    // (R16) locked after reset; (R17) counts untouched
    if (reset)
    begin
      next_r.count_write_unlock    = ctk_pkg::RST_UNLOCK;
      next_r.alarm_irq_enable      = ctk_pkg::RST_IRQEN;
      next_r.decimal_format_select = ctk_pkg::RST_BCD;
      next_r.line_source           = ctk_pkg::RST_SRC;
      next_r.line_50hz             = ctk_pkg::RST_LINE50;
      // (R12) alarm enables cleared
      next_r.al_en                 = ctk_pkg::RST_AL_EN;
      next_r.alarm_match_flag      = 1'b0;
      next_r.irq                   = 1'b0;
      next_r.cmp_pend              = 1'b0;
      next_r.rdata                 = 8'h00;
      next_r.xtal_q                = xtal_clk;
      next_r.line_q                = line_clk;
    end
  end

  always_ff @(posedge mclk)
  begin
    r <= next_r;
  end

endmodule

//--- ctk_line_src.sv
// line-frequency source model feeding the count input
`timescale 1ns/100ps
module ctk_line_src
(
  input  wire logic mclk,
  output logic      line_clk,
  output logic      xtal_clk
);
  initial line_clk = 1'b0;
  initial xtal_clk = 1'b0;
  // free-running crystal, one rising edge per two cycles
  always @(posedge mclk)
  begin
    xtal_clk <= !xtal_clk;
  end
  task automatic pulses(input int n);
    repeat (n)
    begin
      repeat (3) @(posedge mclk);
      line_clk <= 1'b1;
      repeat (3) @(posedge mclk);
      line_clk <= 1'b0;
    end
  endtask
endmodule

//--- ctk_timekeeper_props.sv
// port checks for the calendar timekeeper
`timescale 1ns/100ps
module ctk_timekeeper_props
(
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic [15:0] io_addr,
  input wire logic [7:0]  io_wdata,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic [7:0]  io_rdata,
  input wire logic        alarm_irq
);
  logic [7:0] ctrl_q;
  logic [3:0] en_q;
  logic       sec_known;
  logic       rd_ctrl;
  assign rd_ctrl = io_rd && io_addr == ctk_pkg::OFF_CTRL;
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ctrl_q    <= 8'h00;
      en_q      <= 4'h0;
      sec_known <= 1'b0;
    end
    else if (io_wr)
    begin
      if (io_addr == ctk_pkg::OFF_CTRL)
        ctrl_q <= io_wdata & 8'h79;
      if (io_addr == ctk_pkg::OFF_AL_EN)
        en_q <= io_wdata[3:0];
      if (io_addr == ctk_pkg::OFF_CTRL && io_wdata[5] != ctrl_q[5])
        sec_known <= 1'b0;
      else if (io_addr == ctk_pkg::OFF_SEC && ctrl_q[0])
        sec_known <= 1'b1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  a_reset_quiet: assert property ($past(reset) |-> io_rdata == 8'h00 && !alarm_irq)
    else $error("outputs not idle after reset");
  a_ctrl_readback: assert property (rd_ctrl && !io_wr |=> io_rdata[6:0] == ctrl_q[6:0])
    else $error("control readback wrong");
  a_alen_readback: assert property (io_rd && io_addr == ctk_pkg::OFF_AL_EN |=> io_rdata[3:0] == en_q)
    else $error("alarm enable readback wrong");
  a_flag_visible: assert property (rd_ctrl && alarm_irq |=> io_rdata[7])
    else $error("flag not seen with interrupt");
  a_irq_clear: assert property (rd_ctrl && !io_wr |=> !alarm_irq)
    else $error("interrupt not cleared by read");
  a_irq_holds: assert property (alarm_irq && !rd_ctrl && !io_wr |=> alarm_irq)
    else $error("interrupt dropped uncleared");
  a_irq_needs_en: assert property ($rose(alarm_irq) |-> ctrl_q[6])
    else $error("interrupt without enable");
  a_sec_range: assert property (io_rd && io_addr == ctk_pkg::OFF_SEC && sec_known |=>
    (ctrl_q[5] ? io_rdata[7:4] <= 4'h5 && io_rdata[3:0] <= 4'h9 : io_rdata <= 8'h3b))
    else $error("seconds out of range");
  c_irq_rise: cover property ($rose(alarm_irq));
  c_clear_read: cover property (rd_ctrl && alarm_irq);
  c_lock_write: cover property (io_wr && io_addr == ctk_pkg::OFF_CTRL && !io_wdata[0]);
endmodule
bind ctk_calendar_timekeeper ctk_timekeeper_props u_ctk_timekeeper_props
(
  .mclk      (mclk),
  .reset     (reset),
  .io_addr   (io_addr),
  .io_wdata  (io_wdata),
  .io_wr     (io_wr),
  .io_rd     (io_rd),
  .io_rdata  (io_rdata),
  .alarm_irq (alarm_irq)
);

//--- ctk_calendar_timekeeper_tb.sv
// self-checking bench for the calendar timekeeper
`timescale 1ns/100ps
module ctk_calendar_timekeeper_tb;
  logic        mclk;
  logic        reset;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata;
  logic        io_wr;
  logic        io_rd;
  logic        xtal_clk;
  logic        line_clk;
  logic [7:0]  io_rdata;
  logic        alarm_irq;
  int          fails;
  int          check_count;
  logic [7:0]  set_v [8] = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02, 8'h24, 8'h20};
  logic [7:0]  exp_v [8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h29, 8'h02, 8'h24, 8'h20};

  ctk_calendar_timekeeper u_ctk_calendar_timekeeper
  (
    .mclk      (mclk),
    .reset     (reset),
    .io_addr   (io_addr),
    .io_wdata  (io_wdata),
    .io_wr     (io_wr),
    .io_rd     (io_rd),
    .xtal_clk  (xtal_clk),
    .line_clk  (line_clk),
    .io_rdata  (io_rdata),
    .alarm_irq (alarm_irq)
  );
  ctk_line_src u_ctk_line_src
  (
    .mclk     (mclk),
    .line_clk (line_clk),
    .xtal_clk (xtal_clk)
  );

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    io_addr  <= a;
    io_wdata <= d;
    io_wr    <= 1'b1;
    @(posedge mclk);
    io_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge mclk);
    io_addr <= a;
    io_rd   <= 1'b1;
    @(posedge mclk);
    io_rd <= 1'b0;
    @(negedge mclk);
    chk(io_rdata, e, "read");
  endtask
  task automatic irq_is(input logic e);
    repeat (3) @(negedge mclk);
    chk({7'h00, alarm_irq}, {7'h00, e}, "irq");
  endtask
  task automatic do_reset;
    @(posedge mclk);
    reset <= 1'b1;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial
  begin
    #800000;
    fails++;
    report_and_stop;
  end
  initial
  begin
    reset    <= 1'b1;
    io_addr  <= 16'h0000;
    io_wdata <= 8'h00;
    io_wr    <= 1'b0;
    io_rd    <= 1'b0;
    do_reset;
    rd(ctk_pkg::OFF_CTRL, 8'h00);
    rd(ctk_pkg::OFF_AL_EN, 8'h00);
    rd(16'h00ee, 8'h00);
    $display("test reset done");
    wr(ctk_pkg::OFF_CTRL, 8'h19);
    wr(ctk_pkg::OFF_SEC, 8'h3a);
    wr(ctk_pkg::OFF_MIN, 8'h00);
    u_ctk_line_src.pulses(50);
    rd(ctk_pkg::OFF_SEC, 8'h3a);
    wr(ctk_pkg::OFF_CTRL, 8'h18);
    wr(ctk_pkg::OFF_SEC, 8'h10);
    u_ctk_line_src.pulses(30);
    wr(ctk_pkg::OFF_CTRL, 8'h18);
    u_ctk_line_src.pulses(49);
    rd(ctk_pkg::OFF_SEC, 8'h3a);
    u_ctk_line_src.pulses(1);
    rd(ctk_pkg::OFF_SEC, 8'h3b);
    u_ctk_line_src.pulses(50);
    rd(ctk_pkg::OFF_SEC, 8'h00);
    rd(ctk_pkg::OFF_MIN, 8'h01);
    $display("test binary count done");
    wr(ctk_pkg::OFF_CTRL, 8'h31);
    for (int i = 0; i < 8; i++)
      wr(ctk_pkg::OFF_SEC + 16'(i), set_v[i]);
    wr(ctk_pkg::OFF_CTRL, 8'h30);
    u_ctk_line_src.pulses(60);
    for (int i = 0; i < 8; i++)
      rd(ctk_pkg::OFF_SEC + 16'(i), exp_v[i]);
    $display("test bcd calendar done");
    wr(ctk_pkg::OFF_AL_SEC, 8'h00);
    wr(ctk_pkg::OFF_AL_MIN, 8'h05);
    wr(ctk_pkg::OFF_AL_EN, 8'h03);
    wr(ctk_pkg::OFF_CTRL, 8'h70);
    irq_is(1'b0);
    wr(ctk_pkg::OFF_AL_EN, 8'h01);
    wr(ctk_pkg::OFF_CTRL, 8'h70);
    irq_is(1'b1);
    rd(ctk_pkg::OFF_CTRL, 8'hf0);
    chk({7'h00, alarm_irq}, 8'h00, "irq");
    rd(ctk_pkg::OFF_CTRL, 8'h70);
    wr(ctk_pkg::OFF_AL_SEC, 8'h01);
    rd(ctk_pkg::OFF_AL_SEC, 8'h01);
    u_ctk_line_src.pulses(60);
    irq_is(1'b1);
    rd(ctk_pkg::OFF_CTRL, 8'hf0);
    $display("test alarm done");
    do_reset;
    rd(ctk_pkg::OFF_SEC, 8'h01);
    rd(ctk_pkg::OFF_CTRL, 8'h00);
    $display("test reset keep done");
    repeat (66000) @(posedge mclk);
    rd(ctk_pkg::OFF_SEC, 8'h02);
    $display("test crystal done");
    report_and_stop;
  end
endmodule
